// [hw/address_unit.v]
`timescale 1ns/1ps
`include "data_space_regs.vh"

// ----------------------------------------
// One address unit: forms the byte address and the post-incremented pointer.
// ----------------------------------------
module address_unit (
   input  wire [1:0]  mode,
   input  wire        is_byte,
   input  wire [15:0] direct_addr,
   input  wire [15:0] source_pointer_reg,
   output reg  [15:0] effective_addr,
   output reg  [15:0] pointer_next,
   output wire        misaligned
);
   wire [15:0] step;

   assign step       = is_byte ? `DS_STEP_BYTE : `DS_STEP_WORD;
   assign misaligned = ~is_byte & effective_addr[0];

   always @* begin
      pointer_next = source_pointer_reg;
      case (mode)
         `DS_MODE_NEAR13: begin
            // Near instructions carry 13 address bits; the top three are zero.
            effective_addr = {3'h0, direct_addr[`DS_NEAR_WIDTH-1:0]};
         end
         `DS_MODE_INDIRECT: begin
            effective_addr = source_pointer_reg;
         end
         `DS_MODE_POSTINC: begin
            effective_addr = source_pointer_reg;
            pointer_next   = source_pointer_reg + step;
         end
         default: begin
            effective_addr = direct_addr;
         end
      endcase
   end
endmodule // address_unit

// [hw/byte_lane_ram.v]
`timescale 1ns/1ps

// ----------------------------------------
// Two byte-wide lanes with shared word decode and separate write strobes.
// ----------------------------------------
module byte_lane_ram #(
   parameter WORDS = 4096,
   parameter AW    = 12
) (
   input  wire          clock,
   input  wire [AW-1:0] rd_word,
   output wire [15:0]   rd_data,
   input  wire [AW-1:0] wr_word,
   input  wire [1:0]    wr_lane,
   input  wire [15:0]   wr_data
);
   reg [7:0] lane_lo [0:WORDS-1];
   reg [7:0] lane_hi [0:WORDS-1];

   // Read is asynchronous so a read completes within the access cycle.
   assign rd_data = {lane_hi[rd_word], lane_lo[rd_word]};

   always @(posedge clock) begin
      if (wr_lane[0]) begin
         lane_lo[wr_word] <= wr_data[7:0];
      end
      if (wr_lane[1]) begin
         lane_hi[wr_word] <= wr_data[15:8];
      end
   end
endmodule // byte_lane_ram

// [hw/data_space_access_unit.v]
`timescale 1ns/1ps
`include "data_space_regs.vh"

module data_space_access_unit #(
   parameter [15:0] RAM_LAST = `DS_RAM_LAST_DEFAULT,
   parameter        RAM_WORDS = 4096,
   parameter        RAM_AW    = 12
) (
   input  wire        clock,
   input  wire        nrst,
   input  wire        rd_en,
   input  wire        rd_is_byte,
   input  wire [1:0]  rd_mode,
   input  wire [15:0] rd_direct_addr,
   input  wire [15:0] rd_pointer,
   input  wire        wr_en,
   input  wire        wr_is_byte,
   input  wire [1:0]  wr_mode,
   input  wire [15:0] wr_direct_addr,
   input  wire [15:0] wr_pointer,
   input  wire [15:0] wr_data,
   input  wire [1:0]  ext_op,
   input  wire [15:0] wreg_old,
   input  wire [15:0] sfr_rd_data,
   input  wire        sfr_rd_hit,
   output reg  [15:0] rd_data_reg,
   output reg         rd_valid_reg,
   output reg  [15:0] wreg_new_reg,
   output reg  [15:0] rd_pointer_next_reg,
   output reg  [15:0] wr_pointer_next_reg,
   output reg  [15:0] sfr_wr_addr_reg,
   output reg  [15:0] sfr_wr_data_reg,
   output reg  [1:0]  sfr_wr_lane_reg,
   output reg         addr_error_reg
);
   // ----------------------------------------
   // Address units, one for reads and one for writes.
   // ----------------------------------------
   wire [15:0] rd_ea;
   wire [15:0] wr_ea;
   wire [15:0] rd_ptr_nx;
   wire [15:0] wr_ptr_nx;
   wire        rd_mis;
   wire        wr_mis;

   address_unit u_rd_unit (
      .mode               (rd_mode),
      .is_byte            (rd_is_byte),
      .direct_addr        (rd_direct_addr),
      .source_pointer_reg (rd_pointer),
      .effective_addr     (rd_ea),
      .pointer_next       (rd_ptr_nx),
      .misaligned         (rd_mis)
   );

   address_unit u_wr_unit (
      .mode               (wr_mode),
      .is_byte            (wr_is_byte),
      .direct_addr        (wr_direct_addr),
      .source_pointer_reg (wr_pointer),
      .effective_addr     (wr_ea),
      .pointer_next       (wr_ptr_nx),
      .misaligned         (wr_mis)
   );

   // ----------------------------------------
   // Region decode.
   // ----------------------------------------
   wire rd_in_data;
   wire wr_in_data;
   wire rd_in_sfr;
   wire rd_in_ram;
   wire wr_in_sfr;
   wire wr_in_ram;

   // The upper half belongs to the program-space window, never to data memory.
   assign rd_in_data = ~rd_ea[`DS_PSV_BIT];
   assign wr_in_data = ~wr_ea[`DS_PSV_BIT];
   assign rd_in_sfr  = rd_in_data & (rd_ea <= `DS_SFR_LAST);
   // Above RAM_LAST nothing answers, so such a read falls through to zero.
   assign rd_in_ram  = rd_in_data & ~rd_in_sfr & (rd_ea <= RAM_LAST);
   assign wr_in_sfr  = wr_in_data & (wr_ea <= `DS_SFR_LAST);
   assign wr_in_ram  = wr_in_data & ~wr_in_sfr & (wr_ea <= RAM_LAST);

   // ----------------------------------------
   // Byte lane array.
   // ----------------------------------------
   wire [15:0]       ram_rd;
   wire [RAM_AW-1:0] rd_word;
   wire [RAM_AW-1:0] wr_word;
   wire [1:0]        lane;
   wire [1:0]        ram_lane;
   wire [15:0]       lane_data;
   wire              wr_ok;

   // Both lanes share one word decode; bit 0 of the address only steers bytes.
   assign rd_word = rd_ea[RAM_AW:1];
   assign wr_word = wr_ea[RAM_AW:1];

   // A misaligned write still executes but must not reach memory.
   assign wr_ok    = wr_en & ~wr_mis;
   assign ram_lane = (wr_ok & wr_in_ram) ? lane : 2'h0;

   // A byte write lands only on the lane that address bit 0 picks; a word takes both.
   genvar lane_idx;
   generate
      for (lane_idx = 0; lane_idx < 2; lane_idx = lane_idx + 1) begin : g_lane
         assign lane[lane_idx] = ~wr_is_byte | (wr_ea[0] ^ (lane_idx == 0));
         assign lane_data[lane_idx*8 +: 8] = wr_is_byte ? wr_data[7:0]
                                                        : wr_data[lane_idx*8 +: 8];
      end
   endgenerate

   byte_lane_ram #(
      .WORDS (RAM_WORDS),
      .AW    (RAM_AW)
   ) u_ram (
      .clock   (clock),
      .rd_word (rd_word),
      .rd_data (ram_rd),
      .wr_word (wr_word),
      .wr_lane (ram_lane),
      .wr_data (lane_data)
   );

   // ----------------------------------------
   // Read word source.
   // ----------------------------------------
   reg  [15:0] word_next;

   // Special registers answer only where one exists; every gap reads zero.
   always @* begin
      if (rd_in_ram) begin
         word_next = ram_rd;
      end else if (rd_in_sfr & sfr_rd_hit) begin
         word_next = sfr_rd_data;
      end else begin
         word_next = `DS_RESET_WORD;
      end
   end

   // ----------------------------------------
   // Byte steering onto the low half of the datapath.
   // ----------------------------------------
   reg  [15:0] rd_data_next;
   reg  [15:0] load_next;

   // A byte read always fetches the whole word; bit 0 picks the half.
   always @* begin
      if (rd_is_byte) begin
         rd_data_next = {8'h00, rd_ea[0] ? word_next[15:8] : word_next[7:0]};
         load_next    = {wreg_old[15:8], rd_data_next[7:0]};
      end else begin
         rd_data_next = word_next;
         load_next    = word_next;
      end
   end

   // ----------------------------------------
   // Working register update.
   // ----------------------------------------
   reg  [15:0] wreg_next;

   // An extension works on the register itself and takes priority over a load.
   always @* begin
      case (ext_op)
         `DS_EXT_SIGN: begin
            wreg_next = {{8{wreg_old[7]}}, wreg_old[7:0]};
         end
         `DS_EXT_UPPER_CLEAR: begin
            wreg_next = {8'h00, wreg_old[7:0]};
         end
         default: begin
            wreg_next = rd_en ? load_next : wreg_old;
         end
      endcase
   end

   // ----------------------------------------
   // Next values of the registered outputs.
   // ----------------------------------------
   wire        rd_valid_next;
   wire [15:0] sfr_wr_addr_next;
   wire [15:0] sfr_wr_data_next;
   wire [1:0]  sfr_wr_lane_next;
   wire        addr_error_next;

   // The read instruction completes even when misaligned.
   assign rd_valid_next    = rd_en;
   // Special registers decode per word; the lanes say which bytes change.
   assign sfr_wr_addr_next = {wr_ea[15:1], 1'b0};
   // A byte write repeats its byte on both halves so either lane can take it.
   assign sfr_wr_data_next = lane_data;
   assign sfr_wr_lane_next = (wr_ok & wr_in_sfr) ? lane : 2'h0;
   // One pulse per cycle with a misaligned read or write, even both at once; the trap logic acts on it afterwards.
   assign addr_error_next  = (rd_en & rd_mis) | (wr_en & wr_mis);

   // ----------------------------------------
   // Read answer.
   // ----------------------------------------
   // Both stand for one cycle after the edge that takes the read.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= rd_valid_next;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_data_reg <= `DS_RESET_WORD;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ----------------------------------------
   // Working register.
   // ----------------------------------------
   // Without a read or an extension the register is handed back unchanged.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wreg_new_reg <= `DS_RESET_WORD;
      end else begin
         wreg_new_reg <= wreg_next;
      end
   end

   // ----------------------------------------
   // Pointers.
   // ----------------------------------------
   // Passed on every cycle; the core keeps them only after a post-increment.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_pointer_next_reg <= `DS_RESET_WORD;
      end else begin
         rd_pointer_next_reg <= rd_ptr_nx;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_pointer_next_reg <= `DS_RESET_WORD;
      end else begin
         wr_pointer_next_reg <= wr_ptr_nx;
      end
   end

   // ----------------------------------------
   // Special-register write.
   // ----------------------------------------
   // Address and data mean something only while a lane strobe is set.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sfr_wr_addr_reg <= `DS_RESET_WORD;
      end else begin
         sfr_wr_addr_reg <= sfr_wr_addr_next;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sfr_wr_data_reg <= `DS_RESET_WORD;
      end else begin
         sfr_wr_data_reg <= sfr_wr_data_next;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sfr_wr_lane_reg <= 2'h0;
      end else begin
         sfr_wr_lane_reg <= sfr_wr_lane_next;
      end
   end

   // ----------------------------------------
   // Address error.
   // ----------------------------------------
   // Held for exactly one cycle so the exception logic never takes one fault twice.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         addr_error_reg <= 1'b0;
      end else begin
         addr_error_reg <= addr_error_next;
      end
   end
endmodule // data_space_access_unit

// [hw/data_space_regs.vh]
`ifndef DATA_SPACE_REGS_VH
`define DATA_SPACE_REGS_VH

// ----------------------------------------
// Address map of the data space.
// ----------------------------------------
`define DS_ADDR_WIDTH        16
`define DS_DATA_WIDTH        16
`define DS_PSV_BIT           15
`define DS_SFR_LAST          16'h07FF
`define DS_NEAR_LAST         16'h1FFF
`define DS_NEAR_WIDTH        13
`define DS_RAM_BYTES_MAX     30720
`define DS_RAM_LAST_DEFAULT  16'h1FFF

// ----------------------------------------
// Access sizes and pointer steps.
// ----------------------------------------
`define DS_STEP_BYTE         16'h0001
`define DS_STEP_WORD         16'h0002

// ----------------------------------------
// Addressing modes of the read and write address units.
// ----------------------------------------
`define DS_MODE_DIRECT16     2'h0
`define DS_MODE_NEAR13       2'h1
`define DS_MODE_INDIRECT     2'h2
`define DS_MODE_POSTINC      2'h3

// ----------------------------------------
// Extension operations on a working register.
// ----------------------------------------
`define DS_EXT_NONE          2'h0
`define DS_EXT_SIGN          2'h1
`define DS_EXT_UPPER_CLEAR   2'h2

`define DS_RESET_WORD        16'h0000

`endif

// [verif/data_space_access_unit_tb.sv]
`timescale 1ns/1ps
module data_space_access_unit_tb;
   reg         clock = 1'b0;
   reg         nrst = 1'b0;
   reg         rd_en = 1'b0, rd_is_byte = 1'b0, wr_en = 1'b0, wr_is_byte = 1'b0;
   reg  [1:0]  rd_mode = 2'h0, wr_mode = 2'h0, ext_op = 2'h0;
   reg  [15:0] rd_addr = 16'h0000, wr_addr = 16'h0000, wr_data = 16'h0000, wreg_old = 16'h0000;
   wire [15:0] sfr_rd_data, rd_data_reg, wreg_new_reg, rd_ptr_next, wr_ptr_next, sfr_wa, sfr_wd;
   wire [1:0]  sfr_lane;
   wire        sfr_rd_hit, rd_valid_reg, addr_error_reg;
   integer     bad_count = 0, checked = 0;
   always #5 clock = ~clock;
   data_space_access_unit i_dut (.clock(clock), .nrst(nrst), .rd_en(rd_en),
      .rd_is_byte(rd_is_byte), .rd_mode(rd_mode), .rd_direct_addr(rd_addr), .rd_pointer(rd_addr),
      .wr_en(wr_en), .wr_is_byte(wr_is_byte), .wr_mode(wr_mode), .wr_direct_addr(wr_addr),
      .wr_pointer(wr_addr), .wr_data(wr_data), .ext_op(ext_op), .wreg_old(wreg_old),
      .sfr_rd_data(sfr_rd_data), .sfr_rd_hit(sfr_rd_hit), .rd_data_reg(rd_data_reg),
      .rd_valid_reg(rd_valid_reg), .wreg_new_reg(wreg_new_reg), .rd_pointer_next_reg(rd_ptr_next),
      .wr_pointer_next_reg(wr_ptr_next), .sfr_wr_addr_reg(sfr_wa), .sfr_wr_data_reg(sfr_wd),
      .sfr_wr_lane_reg(sfr_lane), .addr_error_reg(addr_error_reg));
   sfr_model i_sfr (.mode(rd_mode), .direct_addr(rd_addr), .pointer(rd_addr),
      .rd_data(sfr_rd_data), .hit(sfr_rd_hit));
   // ----------------------------------------
   // Shared tasks.
   // ----------------------------------------
   task report_and_stop;
      begin
         $display("checked %0d bad_count %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input string name, input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // One request cycle; the answer is sampled just after the taking edge.
   task rd(input [1:0] m, input b, input [15:0] a);
      begin
         @(posedge clock);
         rd_en <= 1'b1; rd_is_byte <= b; rd_mode <= m; rd_addr <= a;
         @(posedge clock);
         rd_en <= 1'b0;
         #1;
      end
   endtask
   task wr(input [1:0] m, input b, input [15:0] a, input [15:0] d);
      begin
         @(posedge clock);
         wr_en <= 1'b1; wr_is_byte <= b; wr_mode <= m; wr_addr <= a; wr_data <= d;
         @(posedge clock);
         wr_en <= 1'b0;
         #1;
      end
   endtask
   // ----------------------------------------
   // Scenarios.
   // ----------------------------------------
   task t_word;
      begin
         wr(2'h0, 1'b0, 16'h0800, 16'h1234);
         rd(2'h0, 1'b0, 16'h0800);
         chk("word", rd_data_reg, 16'h1234);
         chk("valid", {15'h0, rd_valid_reg}, 16'h0001);
         rd(2'h2, 1'b1, 16'h0801);
         chk("byte hi", rd_data_reg, 16'h0012);
         rd(2'h2, 1'b1, 16'h0800);
         chk("byte lo", rd_data_reg, 16'h0034);
      end
   endtask
   task t_byte;
      begin
         @(posedge clock) wreg_old <= 16'hC300;
         wr(2'h0, 1'b0, 16'h0802, 16'h0000);
         wr(2'h3, 1'b1, 16'h0803, 16'h00AB);
         chk("wr ptr", wr_ptr_next, 16'h0804);
         rd(2'h3, 1'b0, 16'h0802);
         chk("lane", rd_data_reg, 16'hAB00);
         chk("word ptr", rd_ptr_next, 16'h0804);
         rd(2'h3, 1'b1, 16'h0803);
         chk("load", wreg_new_reg, 16'hC3AB);
         chk("byte ptr", rd_ptr_next, 16'h0804);
         wr(2'h0, 1'b1, 16'h0221, 16'h005C);
         chk("sfr lane", {14'h0, sfr_lane}, 16'h0002);
         chk("sfr addr", sfr_wa, 16'h0220);
         chk("sfr data", {8'h00, sfr_wd[15:8]}, 16'h005C);
         wr(2'h1, 1'b0, 16'hE806, 16'h2222);
         wr(2'h2, 1'b1, 16'h0807, 16'h0077);
         rd(2'h0, 1'b0, 16'h0806);
         chk("near wr", rd_data_reg, 16'h7722);
      end
   endtask
   task t_misalign;
      begin
         wr(2'h0, 1'b0, 16'h0804, 16'h1111);
         wr(2'h0, 1'b0, 16'h0805, 16'hBEEF);
         chk("wr err", {15'h0, addr_error_reg}, 16'h0001);
         @(posedge clock);
         #1 chk("err pulse", {15'h0, addr_error_reg}, 16'h0000);
         rd(2'h0, 1'b0, 16'h0804);
         chk("dropped", rd_data_reg, 16'h1111);
         rd(2'h0, 1'b0, 16'h0805);
         chk("rd err", {15'h0, addr_error_reg}, 16'h0001);
         chk("rd done", rd_data_reg, 16'h1111);
      end
   endtask
   task t_zero;
      begin
         rd(2'h0, 1'b0, 16'h8000);
         chk("upper", rd_data_reg, 16'h0000);
         rd(2'h0, 1'b0, 16'h2000);
         chk("unimpl", rd_data_reg, 16'h0000);
         rd(2'h1, 1'b0, 16'hE220);
         chk("near", rd_data_reg, 16'hA55A);
         rd(2'h0, 1'b0, 16'h0300);
         chk("sfr gap", rd_data_reg, 16'h0000);
      end
   endtask
   task t_ext;
      begin
         @(posedge clock);
         ext_op <= 2'h1; wreg_old <= 16'h0080;
         @(posedge clock);
         ext_op <= 2'h2; wreg_old <= 16'h1280;
         #1 chk("sign", wreg_new_reg, 16'hFF80);
         @(posedge clock);
         ext_op <= 2'h0;
         #1 chk("clear", wreg_new_reg, 16'h0080);
      end
   endtask
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      t_word;
      t_byte;
      t_misalign;
      t_zero;
      t_ext;
      report_and_stop;
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      report_and_stop;
   end
endmodule // data_space_access_unit_tb

// [verif/data_space_props.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker.
// ----------------------------------------
module data_space_props (
   input wire        clock,
   input wire        nrst,
   input wire        rd_en,
   input wire        rd_is_byte,
   input wire [1:0]  rd_mode,
   input wire [15:0] rd_direct_addr,
   input wire [15:0] rd_pointer,
   input wire        wr_en,
   input wire        wr_is_byte,
   input wire [1:0]  wr_mode,
   input wire [15:0] wr_direct_addr,
   input wire [1:0]  ext_op,
   input wire [15:0] wreg_old,
   input wire [15:0] rd_data_reg,
   input wire        rd_valid_reg,
   input wire [15:0] wreg_new_reg,
   input wire [15:0] rd_pointer_next_reg,
   input wire [1:0]  sfr_wr_lane_reg,
   input wire        addr_error_reg
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_valid; rd_en |=> rd_valid_reg; endproperty
   a_valid: assert property (p_valid) else $error("read answer missing");
   property p_novalid; !rd_en |=> !rd_valid_reg; endproperty
   a_novalid: assert property (p_novalid) else $error("read answer without request");
   property p_rd_err;
      rd_en && !rd_is_byte && rd_mode == 2'h0 && rd_direct_addr[0] |=> addr_error_reg;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("odd word read not flagged");
   property p_err_cause; !rd_en && !wr_en |=> !addr_error_reg; endproperty
   a_err_cause: assert property (p_err_cause) else $error("error without access");
   property p_byte_ok; rd_en && rd_is_byte && !wr_en |=> !addr_error_reg; endproperty
   a_byte_ok: assert property (p_byte_ok) else $error("byte read flagged");
   property p_inc;
      rd_en && rd_mode == 2'h3 |=>
         rd_pointer_next_reg == $past(rd_pointer) + ($past(rd_is_byte) ? 16'h0001 : 16'h0002);
   endproperty
   a_inc: assert property (p_inc) else $error("pointer step wrong");
   property p_wr_sup;
      wr_en && !wr_is_byte && wr_mode == 2'h0 && wr_direct_addr[0] |=> sfr_wr_lane_reg == 2'h0;
   endproperty
   a_wr_sup: assert property (p_wr_sup) else $error("odd word write not dropped");
   property p_lane;
      wr_en && wr_is_byte && wr_mode == 2'h0 && wr_direct_addr < 16'h0800 |=>
         sfr_wr_lane_reg == {$past(wr_direct_addr[0]), !$past(wr_direct_addr[0])};
   endproperty
   a_lane: assert property (p_lane) else $error("byte lane strobe wrong");
   property p_upper; rd_en && rd_mode == 2'h0 && rd_direct_addr[15] |=> rd_data_reg == 16'h0000;
   endproperty
   a_upper: assert property (p_upper) else $error("upper half read not zero");
   property p_sign;
      ext_op == 2'h1 |=> wreg_new_reg == {{8{$past(wreg_old[7])}}, $past(wreg_old[7:0])};
   endproperty
   a_sign: assert property (p_sign) else $error("sign extension wrong");
endmodule // data_space_props

bind data_space_access_unit data_space_props i_props (.*);

// [verif/sfr_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Special registers: one live word at 0x0220.
// ----------------------------------------
module sfr_model (
   input  wire [1:0]  mode,
   input  wire [15:0] direct_addr,
   input  wire [15:0] pointer,
   output reg  [15:0] rd_data,
   output reg         hit
);
   reg [15:0] ea;
   // A miss drives the inverse pattern, so a design ignoring hit reads nonzero.
   always @* begin
      ea = (mode == 2'h0) ? direct_addr : (mode == 2'h1) ? {3'h0, direct_addr[12:0]} : pointer;
      hit = (ea[15:1] == 15'h0110);
      rd_data = hit ? 16'hA55A : 16'h5AA5;
   end
endmodule // sfr_model
